// File: src/ddhp_host.sv
// host controller driving the dual dac write pins in byte-wide or parallel form
`timescale 1ns/1ns
`include "ddhp_map.svh"
module ddhp_host #(
  parameter int SETUP_CYC = 1,
  parameter int WR_CYC = 2,
  parameter int HOLD_CYC = 1,
  parameter int TW = 4
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // user request
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic req_mode_in,
  input wire logic [1:0] req_chan_mask_in,
  input wire logic [`DDHP_CODE_W-1:0] req_code_in,
  input wire logic req_update_in,
  output logic busy_out,
  // byte-wide variant pins
  output logic chip_sel_n_out,
  output logic latch_sel_hi_out,
  output logic latch_sel_lo_out,
  output logic output_update_strobe_n_out,
  output logic [`DDHP_BYTE_W-1:0] byte_bus_out,
  // parallel variant pins
  output logic chan_a_select_n_out,
  output logic chan_b_select_n_out,
  output logic [`DDHP_CODE_W-1:0] code_bus_out,
  // shared write strobe
  output logic write_n_out
);

  localparam int UPD_CYC = `DDHP_UPD_CYC;

  // data placed on the eight lines for one half of the code
  function automatic logic [`DDHP_BYTE_W-1:0] byte_of(input logic [`DDHP_CODE_W-1:0] code, input logic hi);
    byte_of = hi ? {4'h0, code[`DDHP_NIB_MSB:`DDHP_NIB_LSB]} : code[`DDHP_BYTE_W-1:0];
  endfunction

  logic rst_meta;
  logic rst_n;
  ddhp_pkg::ddhp_state_t state;
  ddhp_pkg::ddhp_state_t next_state;
  ddhp_pkg::ddhp_mode_t mode;
  logic [1:0] mask;
  logic [`DDHP_CODE_W-1:0] code;
  logic upd;
  logic [1:0] step;
  logic [1:0] last_step;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // a request is only taken when it is shown ready, never while the reset copy is still low
  wire accept = req_valid_in && req_ready_out;
  wire expired;
  wire is_byte = (mode == ddhp_pkg::DDHP_BYTE_WIDE);
  wire more_steps = is_byte && (step != last_step);
  wire [1:0] next_mask = accept ? req_chan_mask_in : mask;
  wire [`DDHP_CODE_W-1:0] next_code = accept ? req_code_in : code;
  wire next_byte = accept ? (req_mode_in == 1'b0) : is_byte;
  // b-only transfers start at the b low latch; a transfer ends on the last selected high latch
  wire [1:0] first_step = (req_chan_mask_in == `DDHP_MASK_B) ? `DDHP_ADDR_B_LO : `DDHP_ADDR_A_LO; // R10
  wire [1:0] final_step = req_chan_mask_in[1] ? `DDHP_ADDR_B_HI : `DDHP_ADDR_A_HI; // R10
  wire [1:0] next_step = accept ? first_step :
                         ((state == ddhp_pkg::DDHP_HOLD) && expired && more_steps) ? step + 2'h1 : step;

  always_comb begin
    next_state = state;
    unique case (state)
      ddhp_pkg::DDHP_IDLE: begin
        if (accept) begin
          if (req_chan_mask_in != 2'h0) begin
            next_state = ddhp_pkg::DDHP_SETUP;
          end else if (!req_mode_in && req_update_in) begin
            next_state = ddhp_pkg::DDHP_UPDATE;
          end
        end
      end
      ddhp_pkg::DDHP_SETUP: begin
        if (expired) begin
          next_state = ddhp_pkg::DDHP_STROBE;
        end
      end
      ddhp_pkg::DDHP_STROBE: begin
        if (expired) begin
          next_state = ddhp_pkg::DDHP_HOLD;
        end
      end
      ddhp_pkg::DDHP_HOLD: begin
        if (expired) begin
          if (more_steps) begin
            next_state = ddhp_pkg::DDHP_SETUP;
          end else if (is_byte && upd) begin
            // update goes low on the same edge that chip select returns high, with write already high
            next_state = ddhp_pkg::DDHP_UPDATE; // R13
          end else begin
            next_state = ddhp_pkg::DDHP_IDLE;
          end
        end
      end
      ddhp_pkg::DDHP_UPDATE: begin
        if (expired) begin
          next_state = ddhp_pkg::DDHP_IDLE;
        end
      end
      default: begin
        next_state = ddhp_pkg::DDHP_IDLE;
      end
    endcase
  end

  wire timer_load = (next_state != state) || (next_step != step);
  wire [TW-1:0] timer_val =
    (next_state == ddhp_pkg::DDHP_SETUP) ? TW'(SETUP_CYC - 1) :
    (next_state == ddhp_pkg::DDHP_STROBE) ? TW'(WR_CYC - 1) :
    (next_state == ddhp_pkg::DDHP_HOLD) ? TW'(HOLD_CYC - 1) :
    (next_state == ddhp_pkg::DDHP_UPDATE) ? TW'(UPD_CYC - 1) : TW'(0);

  ddhp_timer #(
    .W(TW)
  ) u_timer (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .load_in(timer_load),
    .load_val_in(timer_val),
    .expired_out(expired)
  );

  // pin levels one cycle ahead, so the pins themselves come from flip-flops
  wire in_cycle = (next_state == ddhp_pkg::DDHP_SETUP) || (next_state == ddhp_pkg::DDHP_STROBE) ||
                  (next_state == ddhp_pkg::DDHP_HOLD);
  wire next_cs_n = !(in_cycle && next_byte); // R1
  wire next_wr_n = (next_state != ddhp_pkg::DDHP_STROBE); // R2 R8
  wire next_a_n = !(in_cycle && !next_byte && next_mask[0]); // R6 R12
  wire next_b_n = !(in_cycle && !next_byte && next_mask[1]); // R7 R12
  wire next_upd_n = (next_state != ddhp_pkg::DDHP_UPDATE); // R3 R11

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ddhp_pkg::DDHP_IDLE;
      mode <= ddhp_pkg::DDHP_BYTE_WIDE;
      mask <= 2'h0;
      code <= 12'h000;
      upd <= 1'b0;
      step <= 2'h0;
      last_step <= 2'h0;
    end else begin
      state <= next_state;
      step <= next_step;
      if (accept) begin
        mode <= ddhp_pkg::ddhp_mode_t'(req_mode_in);
        mask <= req_chan_mask_in;
        code <= req_code_in;
        upd <= req_update_in;
        last_step <= final_step;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chip_sel_n_out <= 1'b1;
      write_n_out <= 1'b1;
      chan_a_select_n_out <= 1'b1;
      chan_b_select_n_out <= 1'b1;
      output_update_strobe_n_out <= 1'b1;
      latch_sel_hi_out <= 1'b0;
      latch_sel_lo_out <= 1'b0;
      byte_bus_out <= 8'h00;
      code_bus_out <= 12'h000;
    end else begin
      chip_sel_n_out <= next_cs_n;
      write_n_out <= next_wr_n;
      chan_a_select_n_out <= next_a_n;
      chan_b_select_n_out <= next_b_n;
      output_update_strobe_n_out <= next_upd_n;
      latch_sel_hi_out <= next_step[1]; // R4
      latch_sel_lo_out <= next_step[0]; // R4
      byte_bus_out <= byte_of(next_code, next_step[0]); // R5
      code_bus_out <= next_code; // R9
    end
  end

  assign req_ready_out = rst_n && (state == ddhp_pkg::DDHP_IDLE);
  assign busy_out = (state != ddhp_pkg::DDHP_IDLE);

  // checks on the pin cycles
  sequence upd_pulse_seq;
    !output_update_strobe_n_out && write_n_out && chip_sel_n_out ##1 output_update_strobe_n_out;
  endsequence

  sequence wr_done_seq;
    write_n_out ##0 (!chip_sel_n_out || !chan_a_select_n_out || !chan_b_select_n_out);
  endsequence

  chk_wr_needs_select: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R1
    !write_n_out |-> (!chip_sel_n_out || !chan_a_select_n_out || !chan_b_select_n_out))
    else $error("write strobe low with no select asserted");

  chk_wr_addr_stable: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R2
    $fell(write_n_out) && !chip_sel_n_out |-> $stable({latch_sel_hi_out, latch_sel_lo_out, byte_bus_out})
      ##1 (!write_n_out && $stable({latch_sel_hi_out, latch_sel_lo_out})) ##1 wr_done_seq)
    else $error("byte write address or select moved during the strobe");

  chk_addr_channel: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R4
    !write_n_out && !chip_sel_n_out |-> (latch_sel_hi_out ? mask[1] : mask[0]))
    else $error("latch address names a channel not requested");

  chk_byte_data: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R5
    !write_n_out && !chip_sel_n_out |->
      byte_bus_out == (latch_sel_lo_out ? {4'h0, code[11:8]} : code[7:0]))
    else $error("byte bus does not carry the selected code half");

  chk_sel_a_mask: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R6
    $rose(write_n_out) && !chan_a_select_n_out |-> $past(mask[0]) && mode == ddhp_pkg::DDHP_PARALLEL)
    else $error("channel a select low without a request for channel a");

  chk_sel_b_mask: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R7
    $rose(write_n_out) && !chan_b_select_n_out |-> $past(mask[1]) && mode == ddhp_pkg::DDHP_PARALLEL)
    else $error("channel b select low without a request for channel b");

  chk_par_word: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R9
    !write_n_out && (!chan_a_select_n_out || !chan_b_select_n_out) |->
      code_bus_out == code ##1 code_bus_out == $past(code_bus_out))
    else $error("parallel bus does not hold the full code through the strobe");

  chk_upd_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R13
    $fell(output_update_strobe_n_out) |-> $past(write_n_out) ##0 upd_pulse_seq)
    else $error("update pulse overlaps write activity or has the wrong width");

endmodule

// File: src/ddhp_map.svh
// constants and timing counts for the dual dac latch host port
//
// Behaviour
// R1: byte-wide writes only take effect while the single active-low chip select is held low.
// R2: a byte-wide write needs write strobe low together with chip select low and both address lines driven.
// R3: pulling the update strobe low copies both input latches into the dac latches.
// R4: the upper address line is the msb and the lower address line the lsb of the input latch selection.
// R5: a low-byte write carries code bits 7..0 on the eight lines, a high-nibble write bits 11..8 on the low four.
// R6: the first channel select low makes a parallel write target the channel a dac latch.
// R7: the second channel select low makes a parallel write target the channel b dac latch.
// R8: the rising edge of the shared write strobe loads parallel data into each selected dac latch.
// R9: a parallel write carries the whole 12-bit code, msb on the top line and bits 10..0 below.
// R10: address codes 00, 01, 10 and 11 open the a low, a high, b low and b high input latches.
// R11: the dac latches follow the input latches while update is low and freeze when it rises.
// R12: both channel selects low at the rising write edge load the same word into both dac latches.
// R13: an update pulse must stay low at least one update pulse width after write activity ends.
// R14: a transparent input latch keeps the value present when chip select or write first goes high.
`ifndef DDHP_MAP_SVH
`define DDHP_MAP_SVH

`define DDHP_CLK_MHZ 20
`define DDHP_T_UPD_NS 50
// least update pulse width, rounded up to whole cycles, never below one
`define DDHP_UPD_RAW ((`DDHP_T_UPD_NS * `DDHP_CLK_MHZ + 999) / 1000)
`define DDHP_UPD_CYC ((`DDHP_UPD_RAW < 1) ? 1 : `DDHP_UPD_RAW)

`define DDHP_ADDR_A_LO 2'h0
`define DDHP_ADDR_A_HI 2'h1
`define DDHP_ADDR_B_LO 2'h2
`define DDHP_ADDR_B_HI 2'h3
`define DDHP_CODE_W 12
`define DDHP_BYTE_W 8
`define DDHP_NIB_LSB 8
`define DDHP_NIB_MSB 11
`define DDHP_MASK_A 2'h1
`define DDHP_MASK_B 2'h2

`endif

// File: src/ddhp_pkg.sv
// types shared by the dual dac latch host port
package ddhp_pkg;

  typedef enum logic [2:0] {
    DDHP_IDLE = 3'h0,
    DDHP_SETUP = 3'h1,
    DDHP_STROBE = 3'h3,
    DDHP_HOLD = 3'h2,
    DDHP_UPDATE = 3'h6
  } ddhp_state_t;

  typedef enum logic {
    DDHP_BYTE_WIDE = 1'b0,
    DDHP_PARALLEL = 1'b1
  } ddhp_mode_t;

endpackage

// File: src/ddhp_timer.sv
// down counter that times each phase of a pin cycle
`timescale 1ns/1ns
module ddhp_timer #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  // status
  output logic expired_out
);

  logic [W-1:0] cnt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
    end else if (load_in) begin
      cnt <= load_val_in;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign expired_out = (cnt == '0);

endmodule

// File: bench/ddhp_dev_model.sv
// behavioural model of the dual dac write pins, both variants
`timescale 1ns/1ns
`include "ddhp_map.svh"
module ddhp_dev_model (
  // byte-wide pins
  input wire logic chip_sel_n_in,
  input wire logic latch_sel_hi_in,
  input wire logic latch_sel_lo_in,
  input wire logic output_update_strobe_n_in,
  input wire logic [`DDHP_BYTE_W-1:0] byte_bus_in,
  // parallel pins
  input wire logic chan_a_select_n_in,
  input wire logic chan_b_select_n_in,
  input wire logic [`DDHP_CODE_W-1:0] code_bus_in,
  input wire logic write_n_in,
  // dac latch contents
  output logic [`DDHP_CODE_W-1:0] byte_dac_a_out,
  output logic [`DDHP_CODE_W-1:0] byte_dac_b_out,
  output logic [`DDHP_CODE_W-1:0] par_dac_a_out,
  output logic [`DDHP_CODE_W-1:0] par_dac_b_out
);
  logic [7:0] a_lo = 8'h00;
  logic [3:0] a_hi = 4'h0;
  logic [7:0] b_lo = 8'h00;
  logic [3:0] b_hi = 4'h0;
  initial begin
    byte_dac_a_out = 12'h000;
    byte_dac_b_out = 12'h000;
    par_dac_a_out = 12'h000;
    par_dac_b_out = 12'h000;
  end
  // transparent input latches, closed when select or write rises
  always @(*) begin
    if (!chip_sel_n_in && !write_n_in) begin
      case ({latch_sel_hi_in, latch_sel_lo_in})
        `DDHP_ADDR_A_LO: a_lo = byte_bus_in;
        `DDHP_ADDR_A_HI: a_hi = byte_bus_in[3:0];
        `DDHP_ADDR_B_LO: b_lo = byte_bus_in;
        default: b_hi = byte_bus_in[3:0];
      endcase
    end
  end
  // dac latches follow while update is low
  always @(*) begin
    if (!output_update_strobe_n_in) begin
      byte_dac_a_out = {a_hi, a_lo};
      byte_dac_b_out = {b_hi, b_lo};
    end
  end
  always @(posedge write_n_in) begin
    if (!chan_a_select_n_in) begin
      par_dac_a_out <= code_bus_in;
    end
    if (!chan_b_select_n_in) begin
      par_dac_b_out <= code_bus_in;
    end
  end
endmodule

// File: bench/tb_dual_dac_latch_host_port.sv
// self-checking bench for the dual dac host controller
`timescale 1ns/1ns
`include "ddhp_map.svh"
module tb_dual_dac_latch_host_port;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic req_valid = 1'b0;
  logic req_mode = 1'b0;
  logic [1:0] req_mask = 2'h0;
  logic [11:0] req_code = 12'h000;
  logic req_update = 1'b0;
  logic ready, busy, cs_n, sel_hi, sel_lo, upd_n, csa_n, csb_n, wr_n;
  logic [7:0] byte_bus;
  logic [11:0] code_bus, bda, bdb, pda, pdb;
  int err_count = 0;
  int checked = 0;

  initial begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  ddhp_host i_ddhp_host (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid),
    .req_ready_out(ready), .req_mode_in(req_mode), .req_chan_mask_in(req_mask), .req_code_in(req_code),
    .req_update_in(req_update), .busy_out(busy), .chip_sel_n_out(cs_n), .latch_sel_hi_out(sel_hi),
    .latch_sel_lo_out(sel_lo), .output_update_strobe_n_out(upd_n), .byte_bus_out(byte_bus),
    .chan_a_select_n_out(csa_n), .chan_b_select_n_out(csb_n), .code_bus_out(code_bus), .write_n_out(wr_n));

  ddhp_dev_model i_ddhp_dev_model (.chip_sel_n_in(cs_n), .latch_sel_hi_in(sel_hi), .latch_sel_lo_in(sel_lo),
    .output_update_strobe_n_in(upd_n), .byte_bus_in(byte_bus), .chan_a_select_n_in(csa_n),
    .chan_b_select_n_in(csb_n), .code_bus_in(code_bus), .write_n_in(wr_n), .byte_dac_a_out(bda),
    .byte_dac_b_out(bdb), .par_dac_a_out(pda), .par_dac_b_out(pdb));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one request through the user port, waiting for idle on both sides
  task automatic send(input logic mode, input logic [1:0] mask, input logic [11:0] code, input logic upd);
    int n;
    n = 0;
    while (ready !== 1'b1) begin
      @(posedge sys_clk_in);
      #1;
      n++;
      if (n > 100) begin
        err_count++;
        wrap_up();
      end
    end
    @(posedge sys_clk_in);
    req_valid <= 1'b1;
    req_mode <= mode;
    req_mask <= mask;
    req_code <= code;
    req_update <= upd;
    @(posedge sys_clk_in);
    req_valid <= 1'b0;
    #1;
    check("busy after request", {11'h000, busy}, {11'h000, (mask != 2'h0) || (!mode && upd)});
    n = 0;
    while (ready !== 1'b1) begin
      @(posedge sys_clk_in);
      #1;
      n++;
      if (n > 100) begin
        err_count++;
        wrap_up();
      end
    end
  endtask

  task automatic t_in_reset();
    check("ready in reset", {11'h000, ready}, 12'h000);
    check("busy in reset", {11'h000, busy}, 12'h000);
    check("chip select in reset", {11'h000, cs_n}, 12'h001);
  endtask

  task automatic t_reset_idle();
    check("ready after reset", {11'h000, ready}, 12'h001);
    check("busy after reset", {11'h000, busy}, 12'h000);
    check("chip select", {11'h000, cs_n}, 12'h001);
    check("write strobe", {11'h000, wr_n}, 12'h001);
    check("update strobe", {11'h000, upd_n}, 12'h001);
    check("channel selects", {10'h000, csb_n, csa_n}, 12'h003);
  endtask

  task automatic t_byte_held_then_update();
    send(1'b0, 2'h1, 12'habc, 1'b0);
    check("dac a before update", bda, 12'h000);
    send(1'b0, 2'h0, 12'h000, 1'b1);
    check("dac a after update", bda, 12'habc);
    check("dac b untouched", bdb, 12'h000);
  endtask

  task automatic t_byte_channels();
    send(1'b0, 2'h2, 12'h123, 1'b1);
    check("dac b", bdb, 12'h123);
    check("dac a kept", bda, 12'habc);
    send(1'b0, 2'h3, 12'hf0f, 1'b1);
    check("dac a both", bda, 12'hf0f);
    check("dac b both", bdb, 12'hf0f);
  endtask

  task automatic t_parallel();
    send(1'b1, 2'h1, 12'h800, 1'b0);
    check("par dac a", pda, 12'h800);
    check("par dac b kept", pdb, 12'h000);
    send(1'b1, 2'h2, 12'h7ff, 1'b0);
    check("par dac b", pdb, 12'h7ff);
    check("par dac a kept", pda, 12'h800);
    send(1'b1, 2'h3, 12'h5a5, 1'b0);
    check("par both a", pda, 12'h5a5);
    check("par both b", pdb, 12'h5a5);
    send(1'b1, 2'h0, 12'h111, 1'b0);
    check("par no-op a", pda, 12'h5a5);
    check("byte side idle a", bda, 12'hf0f);
    check("byte side idle b", bdb, 12'hf0f);
  endtask

  initial begin
    repeat (7) @(posedge sys_clk_in);
    #1;
    t_in_reset();
    @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    #1;
    t_reset_idle();
    t_byte_held_then_update();
    t_byte_channels();
    t_parallel();
    wrap_up();
  end
endmodule
